// ==== cpp_config_port.sv ====
// configuration port pin controller: mode capture, handshake pins, data paths, test port
// Notes on behaviour
// RULE1: boot mode pins are captured when the ready line rises; that is the mode.
// RULE2: a low reconfiguration request starts a fresh configuration sequence.
// RULE3: ready line is held low while not prepared to take configuration data.
// RULE4: done line is released once loading finishes; startup is then in progress.
// RULE5: a test port command can make the test port the configuration port.
// RULE6: first chosen configuration port stays locked until the next power-up.
// RULE7: clock pin is input in slave and processor modes, driven out in master modes.
// RULE8: test state machine runs on test clock, loads from data in, shifts out data.
// RULE9: data bit zero is open-drain in parallel configuration.
// RULE10: in SPI modes data bit zero is output as master, input as slave.
// RULE11: parallel and slave SPI transfers are taken only while select is low.
// RULE12: parallel transfers also need the second select low.
// RULE13: parallel transfers are writes marked by the write strobe.
// RULE14: busy pin shows busy in parallel mode, device data out in SPI modes.
// RULE15: serial data output, or flash select in master SPI modes.
// RULE16: shared pins become user pins whenever configuration is not running.
// RULE17: test mode select steers the test state machine.
`timescale 1ns/1ps
module cpp_config_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] boot_mode,
	input wire logic config_ready_flag_n_in,
	output logic config_ready_flag_n_out,
	output logic config_ready_flag_n_oe,
	input wire logic config_done_in,
	output logic config_done_out,
	output logic config_done_oe,
	input wire logic reconfig_request_n,
	input wire logic config_clock_pin_in,
	output logic config_clock_pin_out,
	output logic config_clock_pin_oe,
	input wire logic config_busy_or_spi_out_in,
	output logic config_busy_or_spi_out_out,
	output logic config_busy_or_spi_out_oe,
	input wire logic config_select_n_in,
	output logic config_select_n_out,
	output logic config_select_n_oe,
	input wire logic config_select_b_n,
	input wire logic config_write_strobe_n,
	output logic serial_out_or_flash_select_out,
	output logic serial_out_or_flash_select_oe,
	input wire logic config_data_bit0_in,
	output logic config_data_bit0_out,
	output logic config_data_bit0_oe,
	input wire logic flash_data_in,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_out,
	output logic tdo_oe,
	input wire logic load_complete,
	input wire cpp_pkg::cpp_gpio_t user_out,
	input wire cpp_pkg::cpp_gpio_t user_oe,
	output cpp_pkg::cpp_gpio_t user_in,
	output logic cfg_bit,
	output logic cfg_bit_valid,
	output cpp_pkg::cpp_mode_t cur_mode,
	output cpp_pkg::cpp_port_t port_sel,
	output logic configuring,
	output logic startup_active
);
	import cpp_pkg::*;

	localparam int PW = $bits(cpp_pins_t);

	cpp_pins_t raw;
	cpp_pins_t pin;
	cpp_pins_t prv;
	logic [PW-1:0] s1, s2, s3, flt;
	cpp_state_t st, next_st;
	cpp_tap_t tap, next_tap;
	logic [15:0] cnt;
	logic [3:0] div;
	logic ccq;
	logic [31:0] hdr;
	logic [5:0] hcnt;
	logic [7:0] ir, ir_sh;
	logic byp, tdo_q, last_bit;

	// pins gathered into one bundle for the three-stage sampler
	assign raw = {boot_mode, config_ready_flag_n_in, config_done_in, reconfig_request_n,
		config_clock_pin_in, config_select_n_in, config_select_b_n, config_write_strobe_n,
		config_data_bit0_in, flash_data_in, config_busy_or_spi_out_in, tck, tms, tdi};

	// three flops; a bit only moves once stages two and three agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= PINS_RST;
			s2 <= PINS_RST;
			s3 <= PINS_RST;
			prv <= PINS_RST;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			prv <= pin;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_flt
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n)
					flt[gi] <= PINS_RST[gi];
				else if (s2[gi] == s3[gi])
					flt[gi] <= s3[gi];
			end
		end
	endgenerate
	assign pin = cpp_pins_t'(flt);

	// edges of the filtered pins; the test clock is sampled, not used as a clock
	wire rdy_rise = pin.ready & ~prv.ready;
	wire config_clock_pin_rise = pin.config_clock_pin & ~prv.config_clock_pin;
	wire tck_rise = pin.tck & ~prv.tck;
	wire tck_fall = ~pin.tck & prv.tck;
	wire req = ~pin.reconfig_n;

	// mode decode
	wire is_mspi = (cur_mode == M_MSPI) || (cur_mode == M_MSPIM);
	wire is_mser = cur_mode == M_MSER;
	wire is_sspi = cur_mode == M_SSPI;
	wire is_par = cur_mode == M_PAR;
	wire is_master = is_mspi | is_mser;
	wire cfg_on = st != S_DONE;
	wire pins_act = (st == S_LOAD) && (port_sel == P_PINS);
	wire tap_act = (st == S_LOAD) && (port_sel == P_TAP);
	wire par_sel = ~pin.sel_n & ~pin.sel_b_n; // [RULE12]
	wire par_wr = par_sel & ~pin.wr_n; // [RULE13]

	// internal clock for master modes: a divider, toggled every half period
	wire tick = pins_act && is_master && (div == 4'h0);
	wire gen_rise = tick & ~ccq;
	wire gen_fall = tick & ccq;
	wire hdr_done = hcnt == SPI_HDR_BITS;

	// one data bit per mode; slave SPI and parallel paths qualify on their selects, slave serial takes every rising clock edge
	wire take_ms = gen_rise & (is_mser | (is_mspi & hdr_done));
	wire take_ss = config_clock_pin_rise & (cur_mode == M_SSER);
	wire take_sp = config_clock_pin_rise & is_sspi & ~pin.sel_n; // [RULE11]
	wire take_pa = config_clock_pin_rise & is_par & par_wr; // [RULE11] [RULE12] [RULE13]
	wire take_pin = pins_act & (take_ms | take_ss | take_sp | take_pa);
	wire take_tap = tap_act & tck_rise & (tap == T_SDR) & (ir == IR_CFG_LOAD); // [RULE5]
	wire next_bit_v = take_pin | take_tap;
	wire next_bit = take_tap ? pin.tdi : (is_mspi ? pin.flash : pin.d0);

	// control sequence; a request low overrides every state
	always_comb begin
		next_st = st;
		unique case (st)
			S_CLEAR: if (cnt == 16'h0000 && !req) next_st = S_WAIT;
			S_WAIT: if (rdy_rise) next_st = S_LOAD;
			S_LOAD: if (load_complete) next_st = S_DONE;
			S_DONE: next_st = S_DONE;
		endcase
		if (req)
			next_st = S_CLEAR; // [RULE2]
	end

	// clear phase holds for a minimum time after the request goes away
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= S_CLEAR;
			cnt <= 16'(CLEAR_CYC);
		end else begin
			st <= next_st;
			if (req)
				cnt <= 16'(CLEAR_CYC);
			else if (st == S_CLEAR && cnt != 16'h0000)
				cnt <= cnt - 16'h0001;
		end
	end

	// port choice is cleared by power-up reset only, never by a reconfiguration
	wire tap_claim = tck_rise && (tap == T_UIR) && (ir_sh == IR_CFG_ENABLE);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_sel <= P_NONE;
			cur_mode <= M_SSER;
		end else if (port_sel == P_NONE && tap_claim) begin
			port_sel <= P_TAP; // [RULE5] [RULE6]
		end else if (st == S_WAIT && rdy_rise && port_sel != P_TAP) begin
			port_sel <= P_PINS; // [RULE6]
			cur_mode <= cpp_mode_t'(pin.boot_mode); // [RULE1]
		end
	end

	// master clock divider and SPI read header
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 4'h0;
			ccq <= 1'b0;
			hdr <= 32'h00000000;
			hcnt <= 6'h00;
		end else if (!pins_act) begin
			div <= 4'h0;
			ccq <= 1'b0;
			hdr <= {SPI_READ_CMD, SPI_START_ADDR};
			hcnt <= 6'h00;
		end else begin
			div <= (div == 4'h0) ? 4'(CONFIG_CLOCK_PIN_HALF_CYC - 1) : div - 4'h1;
			if (tick)
				ccq <= ~ccq;
			if (gen_rise && is_mspi && !hdr_done)
				hcnt <= hcnt + 6'h01;
			if (gen_fall)
				hdr <= {hdr[30:0], 1'b0};
		end
	end

	// test state machine, advanced on each sampled rising test clock edge
	always_comb begin
		next_tap = tap;
		unique case (tap)
			T_TLR: next_tap = pin.tms ? T_TLR : T_RTI; // [RULE17]
			T_RTI: next_tap = pin.tms ? T_SDRS : T_RTI;
			T_SDRS: next_tap = pin.tms ? T_SIRS : T_CDR;
			T_CDR: next_tap = pin.tms ? T_E1D : T_SDR;
			T_SDR: next_tap = pin.tms ? T_E1D : T_SDR;
			T_E1D: next_tap = pin.tms ? T_UDR : T_PDR;
			T_PDR: next_tap = pin.tms ? T_E2D : T_PDR;
			T_E2D: next_tap = pin.tms ? T_UDR : T_SDR;
			T_UDR: next_tap = pin.tms ? T_SDRS : T_RTI;
			T_SIRS: next_tap = pin.tms ? T_TLR : T_CIR;
			T_CIR: next_tap = pin.tms ? T_E1I : T_SIR;
			T_SIR: next_tap = pin.tms ? T_E1I : T_SIR;
			T_E1I: next_tap = pin.tms ? T_UIR : T_PIR;
			T_PIR: next_tap = pin.tms ? T_E2I : T_PIR;
			T_E2I: next_tap = pin.tms ? T_UIR : T_SIR;
			T_UIR: next_tap = pin.tms ? T_SDRS : T_RTI;
		endcase
	end

	// instruction and bypass paths; data leaves on the falling test clock edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tap <= T_TLR;
			ir <= IR_BYPASS;
			ir_sh <= IR_CAPTURE;
			byp <= 1'b0;
			tdo_q <= 1'b0;
		end else begin
			if (tck_rise) begin
				tap <= next_tap; // [RULE8] [RULE17]
				if (tap == T_TLR)
					ir <= IR_BYPASS;
				if (tap == T_CIR)
					ir_sh <= IR_CAPTURE;
				if (tap == T_SIR)
					ir_sh <= {pin.tdi, ir_sh[7:1]}; // [RULE8]
				if (tap == T_UIR)
					ir <= ir_sh;
				if (tap == T_CDR)
					byp <= 1'b0;
				if (tap == T_SDR)
					byp <= pin.tdi; // [RULE8]
			end
			if (tck_fall)
				tdo_q <= (tap == T_SIR) ? ir_sh[0] : byp; // [RULE8]
		end
	end

	// pin drive values before the output flops
	wire spi_oe = is_mspi | (is_sspi & ~pin.sel_n);
	wire next_busy_o = is_par ? next_bit_v : last_bit; // [RULE14]
	wire next_busy_oe = pins_act & (is_par | spi_oe); // [RULE14]
	wire next_dout_o = is_mspi ? 1'b0 : last_bit; // [RULE15]
	wire next_d0_o = is_mspi ? hdr[31] : 1'b0; // [RULE10]
	wire next_d0_oe = is_mspi | (is_par & par_sel & pin.wr_n & cfg_bit_valid); // [RULE9]

	// one register stage for every output
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			config_ready_flag_n_out <= 1'b0;
			config_ready_flag_n_oe <= 1'b1;
			config_done_out <= 1'b0;
			config_done_oe <= 1'b1;
			config_clock_pin_out <= 1'b0;
			config_clock_pin_oe <= 1'b0;
			config_busy_or_spi_out_out <= 1'b0;
			config_busy_or_spi_out_oe <= 1'b0;
			config_select_n_out <= 1'b0;
			config_select_n_oe <= 1'b0;
			serial_out_or_flash_select_out <= 1'b1;
			serial_out_or_flash_select_oe <= 1'b0;
			config_data_bit0_out <= 1'b0;
			config_data_bit0_oe <= 1'b0;
			tdo_out <= 1'b0;
			tdo_oe <= 1'b0;
			user_in <= 4'h0;
			cfg_bit <= 1'b0;
			cfg_bit_valid <= 1'b0;
			last_bit <= 1'b0;
			configuring <= 1'b1;
			startup_active <= 1'b0;
		end else begin
			config_ready_flag_n_oe <= st == S_CLEAR; // [RULE3]
			config_done_oe <= cfg_on; // [RULE4]
			startup_active <= st == S_DONE; // [RULE4]
			configuring <= cfg_on;
			config_clock_pin_out <= ccq;
			config_clock_pin_oe <= pins_act & is_master; // [RULE7]
			tdo_out <= tdo_q;
			tdo_oe <= (tap == T_SDR) || (tap == T_SIR); // [RULE8]
			cfg_bit <= next_bit;
			cfg_bit_valid <= next_bit_v;
			if (next_bit_v)
				last_bit <= next_bit;
			if (cfg_on) begin
				// released shared pins stay quiet until loading actually starts
				config_busy_or_spi_out_out <= next_busy_o;
				config_busy_or_spi_out_oe <= next_busy_oe;
				config_select_n_out <= 1'b0;
				config_select_n_oe <= 1'b0;
				serial_out_or_flash_select_out <= next_dout_o; // [RULE15]
				serial_out_or_flash_select_oe <= pins_act;
				config_data_bit0_out <= next_d0_o;
				config_data_bit0_oe <= pins_act & next_d0_oe; // [RULE9] [RULE10]
				user_in <= 4'h0;
			end else begin
				config_busy_or_spi_out_out <= user_out.busy; // [RULE16]
				config_busy_or_spi_out_oe <= user_oe.busy;
				config_select_n_out <= user_out.sel;
				config_select_n_oe <= user_oe.sel;
				serial_out_or_flash_select_out <= user_out.dout;
				serial_out_or_flash_select_oe <= user_oe.dout;
				config_data_bit0_out <= user_out.d0;
				config_data_bit0_oe <= user_oe.d0;
				user_in <= {pin.busy, pin.sel_n, pin.d0, 1'b0}; // [RULE16]
			end
		end
	end
endmodule

// ==== cpp_config_port_sva.sv ====
// assertions on the pins of the configuration port controller
`timescale 1ns/1ps
module cpp_config_port_sva
	import cpp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reconfig_request_n,
	input wire logic config_ready_flag_n_oe,
	input wire logic config_done_oe,
	input wire logic config_clock_pin_oe,
	input wire logic config_data_bit0_oe,
	input wire logic config_data_bit0_out,
	input wire logic config_busy_or_spi_out_out,
	input wire logic config_busy_or_spi_out_oe,
	input wire logic serial_out_or_flash_select_out,
	input wire logic serial_out_or_flash_select_oe,
	input wire logic cfg_bit_valid,
	input wire cpp_pkg::cpp_mode_t cur_mode,
	input wire cpp_pkg::cpp_port_t port_sel,
	input wire logic configuring,
	input wire logic startup_active,
	input wire cpp_pkg::cpp_gpio_t user_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// eight cycles covers the input filter plus the state register
	property p_req; !reconfig_request_n [*8] |-> config_ready_flag_n_oe; endproperty
	a_req: assert property (p_req) else $error("ready line free under request");
	property p_ready; config_ready_flag_n_oe |-> !cfg_bit_valid; endproperty
	a_ready: assert property (p_ready) else $error("bit taken while not ready");
	property p_done; startup_active |-> !config_done_oe && !configuring; endproperty
	a_done: assert property (p_done) else $error("done held in startup");
	property p_lock; port_sel != P_NONE |=> $stable(port_sel); endproperty
	a_lock: assert property (p_lock) else $error("port choice changed");
	property p_clk; !(cur_mode inside {M_MSPI, M_MSPIM, M_MSER}) |-> !config_clock_pin_oe;
	endproperty
	a_clk: assert property (p_clk) else $error("clock driven in slave mode");
	property p_d0; configuring && config_clock_pin_oe && cur_mode == M_MSPI
		|-> config_data_bit0_oe; endproperty
	a_d0: assert property (p_d0) else $error("master not driving data bit");
	// open drain: in parallel loading the data bit may only ever be pulled low
	property p_od; configuring && cur_mode == M_PAR && config_data_bit0_oe
		|-> !config_data_bit0_out; endproperty
	a_od: assert property (p_od) else $error("data bit driven high");
	// busy is a copy of the taken-bit strobe while parallel loading runs
	property p_busy; configuring && !config_ready_flag_n_oe && cur_mode == M_PAR
		&& config_busy_or_spi_out_oe |-> config_busy_or_spi_out_out == cfg_bit_valid;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not tracking bits");
	property p_flash; configuring && cur_mode == M_MSPI && serial_out_or_flash_select_oe
		|-> !serial_out_or_flash_select_out; endproperty
	a_flash: assert property (p_flash) else $error("flash not selected");
	// one settled cycle first, so the hand-over edge itself is not judged
	property p_user; !configuring && !$past(configuring) |->
		config_busy_or_spi_out_oe == $past(user_oe.busy) &&
		config_data_bit0_oe == $past(user_oe.d0); endproperty
	a_user: assert property (p_user) else $error("shared pins not user owned");
	c_bit: cover property (cfg_bit_valid);
	c_tap: cover property (port_sel == P_TAP);
	c_start: cover property ($rose(startup_active));
endmodule
bind cpp_config_port cpp_config_port_sva chk_u (.mclk(mclk), .rst_n(rst_n),
	.reconfig_request_n(reconfig_request_n),
	.config_ready_flag_n_oe(config_ready_flag_n_oe),
	.config_done_oe(config_done_oe), .config_clock_pin_oe(config_clock_pin_oe),
	.config_data_bit0_oe(config_data_bit0_oe),
	.config_data_bit0_out(config_data_bit0_out),
	.config_busy_or_spi_out_out(config_busy_or_spi_out_out),
	.config_busy_or_spi_out_oe(config_busy_or_spi_out_oe),
	.serial_out_or_flash_select_out(serial_out_or_flash_select_out),
	.serial_out_or_flash_select_oe(serial_out_or_flash_select_oe),
	.cfg_bit_valid(cfg_bit_valid), .cur_mode(cur_mode), .port_sel(port_sel),
	.configuring(configuring), .startup_active(startup_active), .user_oe(user_oe));

// ==== cpp_config_port_tb.sv ====
// self-checking bench for the configuration port controller
`timescale 1ns/1ps
module cpp_config_port_tb;
	import cpp_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, reconfig_request_n = 1'b1, config_select_b_n = 1'b1;
	logic config_write_strobe_n = 1'b1, flash_data_in = 1'b1, tck = 1'b0, tms = 1'b1;
	logic tdi = 1'b0, load_complete = 1'b0, sel_drv = 1'b1, host_clk, host_d0, toe;
	logic [2:0] boot_mode = 3'h3;
	cpp_gpio_t user_out = 4'h8, user_oe = 4'h8, user_in;
	logic config_ready_flag_n_in, config_ready_flag_n_out, config_ready_flag_n_oe;
	logic config_done_in, config_done_out, config_done_oe, config_clock_pin_in;
	logic config_clock_pin_out, config_clock_pin_oe, config_busy_or_spi_out_in;
	logic config_busy_or_spi_out_out, config_busy_or_spi_out_oe, config_select_n_in;
	logic config_select_n_out, config_select_n_oe, serial_out_or_flash_select_out;
	logic serial_out_or_flash_select_oe, config_data_bit0_in, config_data_bit0_out;
	logic config_data_bit0_oe, tdo_out, tdo_oe, cfg_bit, cfg_bit_valid, configuring;
	logic startup_active;
	cpp_mode_t cur_mode;
	cpp_port_t port_sel;
	logic [7:0] rx = 8'h00, nb = 8'h00, tq;
	int errors = 0, n_tests = 0, cycles = 0;
	// open-drain lines rest high on their pull-ups; shared pins go to whoever enables
	assign config_ready_flag_n_in = ~config_ready_flag_n_oe;
	assign config_done_in = ~config_done_oe;
	assign config_clock_pin_in = config_clock_pin_oe ? config_clock_pin_out : host_clk;
	assign config_data_bit0_in = config_data_bit0_oe ? config_data_bit0_out : host_d0;
	assign config_select_n_in = config_select_n_oe ? config_select_n_out : sel_drv;
	assign config_busy_or_spi_out_in = config_busy_or_spi_out_oe ?
		config_busy_or_spi_out_out : 1'b1;
	cpp_config_port dut_u (.mclk(mclk), .rst_n(rst_n), .boot_mode(boot_mode),
		.config_ready_flag_n_in(config_ready_flag_n_in),
		.config_ready_flag_n_out(config_ready_flag_n_out),
		.config_ready_flag_n_oe(config_ready_flag_n_oe),
		.config_done_in(config_done_in), .config_done_out(config_done_out),
		.config_done_oe(config_done_oe), .reconfig_request_n(reconfig_request_n),
		.config_clock_pin_in(config_clock_pin_in),
		.config_clock_pin_out(config_clock_pin_out),
		.config_clock_pin_oe(config_clock_pin_oe),
		.config_busy_or_spi_out_in(config_busy_or_spi_out_in),
		.config_busy_or_spi_out_out(config_busy_or_spi_out_out),
		.config_busy_or_spi_out_oe(config_busy_or_spi_out_oe),
		.config_select_n_in(config_select_n_in),
		.config_select_n_out(config_select_n_out),
		.config_select_n_oe(config_select_n_oe), .config_select_b_n(config_select_b_n),
		.config_write_strobe_n(config_write_strobe_n),
		.serial_out_or_flash_select_out(serial_out_or_flash_select_out),
		.serial_out_or_flash_select_oe(serial_out_or_flash_select_oe),
		.config_data_bit0_in(config_data_bit0_in),
		.config_data_bit0_out(config_data_bit0_out),
		.config_data_bit0_oe(config_data_bit0_oe), .flash_data_in(flash_data_in),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
		.load_complete(load_complete), .user_out(user_out), .user_oe(user_oe),
		.user_in(user_in), .cfg_bit(cfg_bit), .cfg_bit_valid(cfg_bit_valid),
		.cur_mode(cur_mode), .port_sel(port_sel), .configuring(configuring),
		.startup_active(startup_active));
	cpp_host_model host_u (.config_clock_pin(host_clk), .d0(host_d0));
	always #5 mclk = ~mclk;
	// gather taken bits first-sent first, so a whole byte reads back as sent
	always @(posedge mclk) begin
		if (cfg_bit_valid === 1'b1) begin
			rx <= {rx[6:0], cfg_bit};
			nb <= nb + 8'h01;
		end
	end
	// a hang ends the run well past the expected run of under two thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			close_out();
		end
	end
	task automatic close_out();
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 400 && config_ready_flag_n_oe !== 1'b0; i++)
			@(posedge mclk);
		chk(config_ready_flag_n_oe, 8'h00);
		repeat (10) @(posedge mclk);
	endtask
	// one slow test clock period; output is sampled just before the rising edge
	// tdo settles six clocks after tck falls, so the seventh clock is the first safe look
	task automatic tick(input logic m, input logic d);
		tms <= m;
		tdi <= d;
		repeat (7) @(posedge mclk);
		tq = {tdo_out, tq[7:1]};
		toe = toe & tdo_oe;
		tck <= 1'b1;
		repeat (6) @(posedge mclk);
		tck <= 1'b0;
	endtask
	// reset the test state machine, walk to instruction shift and load a code
	task automatic tap_ir(input logic [7:0] ir);
		for (int i = 0; i < 10; i++)
			tick(i < 5 || i == 6 || i == 7, 1'b0);
		toe = 1'b1;
		for (int i = 0; i < 8; i++)
			tick(i == 7, ir[i]);
		chk(tq, IR_CAPTURE);
		chk(toe, 8'h01);
		tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
		repeat (10) @(posedge mclk);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(config_ready_flag_n_oe, 8'h01);
		wait_ready();
		boot_mode <= M_PAR;
		repeat (10) @(posedge mclk);
		chk(cur_mode, M_SSER);
		chk(config_clock_pin_oe, 8'h00);
		host_u.send(8'hA5);
		repeat (10) @(posedge mclk);
		chk(rx, 8'hA5);
		tap_ir(IR_CFG_ENABLE);
		chk(port_sel, P_PINS);
		// reconfigure into parallel; first byte lacks the second select
		reconfig_request_n <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(config_ready_flag_n_oe, 8'h01);
		reconfig_request_n <= 1'b1;
		wait_ready();
		chk(cur_mode, M_PAR);
		sel_drv <= 1'b0;
		config_write_strobe_n <= 1'b0;
		host_u.send(8'h3C);
		repeat (10) @(posedge mclk);
		chk(nb, 8'h08);
		config_select_b_n <= 1'b0;
		host_u.send(8'h3C);
		repeat (10) @(posedge mclk);
		chk(rx, 8'h3C);
		chk(nb, 8'h10);
		chk(config_busy_or_spi_out_oe, 8'h01);
		chk(config_data_bit0_out, 8'h00);
		sel_drv <= 1'b1;
		config_write_strobe_n <= 1'b1;
		config_select_b_n <= 1'b1;
		// slave SPI: a byte with select high is refused, the next one is taken
		boot_mode <= M_SSPI;
		reconfig_request_n <= 1'b0;
		repeat (10) @(posedge mclk);
		reconfig_request_n <= 1'b1;
		wait_ready();
		host_u.send(8'h96);
		repeat (10) @(posedge mclk);
		chk(nb, 8'h10);
		sel_drv <= 1'b0;
		host_u.send(8'h69);
		repeat (10) @(posedge mclk);
		chk(rx, 8'h69);
		chk(config_data_bit0_oe, 8'h00);
		chk(config_busy_or_spi_out_oe, 8'h01);
		chk(config_busy_or_spi_out_out, 8'h01);
		sel_drv <= 1'b1;
		// reconfigure as flash master, then finish loading
		boot_mode <= M_MSPI;
		reconfig_request_n <= 1'b0;
		repeat (10) @(posedge mclk);
		reconfig_request_n <= 1'b1;
		wait_ready();
		chk(config_clock_pin_oe, 8'h01);
		chk(config_data_bit0_oe, 8'h01);
		chk(serial_out_or_flash_select_out, 8'h00);
		chk(serial_out_or_flash_select_oe, 8'h01);
		load_complete <= 1'b1;
		@(posedge mclk);
		load_complete <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(config_done_oe, 8'h00);
		chk(startup_active, 8'h01);
		chk(config_busy_or_spi_out_oe, 8'h01);
		chk(config_busy_or_spi_out_out, 8'h01);
		chk(config_data_bit0_oe, 8'h00);
		chk(user_in.d0, host_d0);
		// fresh power-up: the test port claims first, later pin capture is refused
		rst_n <= 1'b0;
		reconfig_request_n <= 1'b0;
		boot_mode <= M_PAR;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		tap_ir(IR_CFG_ENABLE);
		chk(port_sel, P_TAP);
		reconfig_request_n <= 1'b1;
		wait_ready();
		chk(cur_mode, M_SSER);
		close_out();
	end
endmodule

// ==== cpp_host_model.sv ====
// far-side host: drives the configuration clock and data bit zero in slave modes
`timescale 1ns/1ps
module cpp_host_model (
	output logic config_clock_pin,
	output logic d0
);
	initial begin
		config_clock_pin = 1'b0;
		d0 = 1'b0;
	end
	// clock stands still between frames; d0 flips after a frame so stale data never looks held
	task automatic send(input logic [7:0] data);
		for (int i = 7; i >= 0; i--) begin
			d0 = data[i];
			#62.5 config_clock_pin = 1'b1;
			#62.5 config_clock_pin = 1'b0;
		end
		d0 = ~d0;
	endtask
endmodule

// ==== cpp_pkg.sv ====
// shared constants, states and pin bundles of the configuration port controller
package cpp_pkg;
	localparam int CLK_NS = 10;
	localparam int CLEAR_NS = 1000;
	localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONFIG_CLOCK_PIN_HALF_NS = 40;
	localparam int CONFIG_CLOCK_PIN_HALF_CYC = CONFIG_CLOCK_PIN_HALF_NS / CLK_NS;
	localparam logic [7:0] SPI_READ_CMD = 8'h03;
	localparam logic [23:0] SPI_START_ADDR = 24'h000000;
	localparam logic [5:0] SPI_HDR_BITS = 6'h20;
	localparam logic [7:0] IR_CFG_ENABLE = 8'hC6;
	localparam logic [7:0] IR_CFG_LOAD = 8'h7A;
	localparam logic [7:0] IR_BYPASS = 8'hFF;
	localparam logic [7:0] IR_CAPTURE = 8'h01;
	typedef enum logic [2:0] {M_MSPI = 3'h0, M_MSPIM = 3'h1, M_SSPI = 3'h2, M_SSER = 3'h3,
		M_PAR = 3'h4, M_MSER = 3'h5, M_RSV6 = 3'h6, M_RSV7 = 3'h7} cpp_mode_t;
	typedef enum logic [1:0] {P_NONE = 2'h0, P_PINS = 2'h1, P_TAP = 2'h2} cpp_port_t;
	typedef enum logic [3:0] {S_CLEAR = 4'h1, S_WAIT = 4'h2, S_LOAD = 4'h4,
		S_DONE = 4'h8} cpp_state_t;
	typedef enum logic [15:0] {T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDRS = 16'h0004,
		T_CDR = 16'h0008, T_SDR = 16'h0010, T_E1D = 16'h0020, T_PDR = 16'h0040,
		T_E2D = 16'h0080, T_UDR = 16'h0100, T_SIRS = 16'h0200, T_CIR = 16'h0400,
		T_SIR = 16'h0800, T_E1I = 16'h1000, T_PIR = 16'h2000, T_E2I = 16'h4000,
		T_UIR = 16'h8000} cpp_tap_t;
	// shared pins as seen by user logic once configuration is over
	typedef struct packed {
		logic busy;
		logic sel;
		logic d0;
		logic dout;
	} cpp_gpio_t;
	// every pin input that is sampled from outside the mclk domain
	typedef struct packed {
		logic [2:0] boot_mode;
		logic ready;
		logic done;
		logic reconfig_n;
		logic config_clock_pin;
		logic sel_n;
		logic sel_b_n;
		logic wr_n;
		logic d0;
		logic flash;
		logic busy;
		logic tck;
		logic tms;
		logic tdi;
	} cpp_pins_t;
	localparam cpp_pins_t PINS_RST = 16'h1FF1;
endpackage
